/* core/weld_count_pkg.sv */
package weld_count_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] MODE_SEL_OFS    = 8'h04;
  localparam logic [7:0] MODE_DATA_OFS   = 8'h08;
  localparam logic [7:0] KEY_OFS         = 8'h0C;
  localparam logic [7:0] WELD_PRESET_OFS = 8'h10;
  localparam logic [7:0] WORK_PRESET_OFS = 8'h14;
  localparam logic [7:0] WELD_COUNT_OFS  = 8'h18;
  localparam logic [7:0] WORK_COUNT_OFS  = 8'h1C;
  localparam logic [7:0] MAX_CURR_OFS    = 8'h20;
  localparam logic [7:0] HIGH_LIM_OFS    = 8'h24;
  localparam logic [7:0] LOW_LIM_OFS     = 8'h28;
  localparam logic [7:0] STATUS_OFS      = 8'h2C;
  localparam logic [7:0] MASK_OFS        = 8'h30;
  localparam logic [7:0] ERROR_CODE_OFS  = 8'h34;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_COUNT_EN_BIT  = 0;
  localparam int KEY_RESET_BIT      = 0;
  localparam int KEY_CAUTION_CLR    = 1;
  localparam int ST_WELD_HIT        = 0;
  localparam int ST_WORK_HIT        = 1;
  localparam int ST_WINDOW_FAIL     = 2;
  localparam int ST_RATIO_ERR       = 3;
  localparam int ST_REFUSED         = 4;
  localparam int STATUS_W           = 5;

  // ------------------------------------------------------------------
  // panel modes and values
  // ------------------------------------------------------------------
  localparam logic [3:0] MODE_WELD_CNT   = 4'h3;
  localparam logic [3:0] MODE_WORK_CNT   = 4'h4;
  localparam logic [3:0] MODE_TURN_RATIO = 4'h5;
  localparam logic [3:0] MODE_WINDOW     = 4'h6;
  localparam logic [3:0] MODE_WELD_SW    = 4'h7;
  localparam logic [3:0] MODE_CORR_G1    = 4'h8;
  localparam logic [3:0] MODE_CORR_G2    = 4'h9;
  localparam logic [3:0] MODE_MAX_BASIC  = 4'h7;
  localparam logic [3:0] MODE_MAX_EXT    = 4'h9;

  typedef enum logic [1:0] {
    WELD_NORMAL,
    WELD_FAST_RISE,
    WELD_MIXED
  } weld_mode_e;

  // ------------------------------------------------------------------
  // reset values, limits, codes, timing
  // ------------------------------------------------------------------
  localparam logic [15:0] CORR_NOMINAL   = 16'h0032;  // 50
  localparam logic [31:0] RATIO_MIN      = 32'h0000_0032;  // 50
  localparam logic [31:0] RATIO_MAX      = 32'h0000_05DC;  // 1500
  localparam logic [7:0]  ERR_CODE_RATIO = 8'h03;
  localparam int CLK_FREQ_KHZ  = 200_000;
  localparam int BUZZ_TIME_MS  = 1000;  // weld preset beep length
  localparam int BEEP_TIME_MS  = 250;   // intermittent on/off half period
  localparam int BUZZ_CYCLES   = CLK_FREQ_KHZ * BUZZ_TIME_MS;
  localparam int BEEP_CYCLES   = CLK_FREQ_KHZ * BEEP_TIME_MS;

endpackage

/* core/weld_work_counter_control.sv */
// Behaviour
// [RQ1] each weld counter preset hit adds one to the work counter; here hits add nothing once the work preset is reached
// [RQ2] work preset reached: display blinks and buzzer sounds intermittently
// [RQ3] work preset reached with interlock off drives count-up output
// [RQ4] counters advance only while counting is enabled, lamp shows it
// [RQ5] interlock on: only panel reset key in mode 4 clears work count
// [RQ6] interlock off: panel key in mode 4 or external reset clears work
// [RQ7] weld counter cleared by key in mode 3, external only if interlock off
// [RQ8] at power-on, max current over turn ratio outside 50..1500 gives error 03
// [RQ9] mode 5 holds turn ratio, applied under primary constant-current control
// [RQ10] window on: current above high or below low lights caution and error
// [RQ11] window off: currents are not judged and raise no alarm
// [RQ12] mode 7 value 0: normal welding, method switch picks control for all
// [RQ13] mode 7 value 1: fast-rise constant current, only with method switch off
// [RQ14] mode 7 value 2: compensation first interval, then constant current
// [RQ15] mode 8 holds first rise correction, nominal 50, extended switch only
// [RQ16] mode 9 holds second rise correction, same extended condition
// [RQ17] mode selector offers 0..7, or 0..9 with extended switch on
// [RQ18] weld preset hit beeps one second and returns the counter to zero
// [RQ19] any counter clear zeroes it and stops its blink or buzzer
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module weld_work_counter_control #(
  parameter int          CNT_W         = 16,
  parameter int          BUZZ_CYCLES   = weld_count_pkg::BUZZ_CYCLES,
  parameter int          BEEP_CYCLES   = weld_count_pkg::BEEP_CYCLES,
  parameter logic [15:0] MAX_CURR_INIT = 16'h2710,
  parameter logic [15:0] RATIO_INIT    = 16'h002C
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [7:0]        address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  output logic [31:0]            readdata_o,
  output logic                   waitrequest_o,
  input  wire logic              interlock_select_switch_i,
  input  wire logic              control_method_switch_i,
  input  wire logic              extended_mode_switch_i,
  input  wire logic              primary_cc_select_i,
  input  wire logic              weld_done_i,
  input  wire logic              ext_count_reset_i,
  input  wire logic              meas_valid_i,
  input  wire logic [15:0]       meas_current_i,
  output logic                   count_lamp_o,
  output logic                   count_up_o,
  output logic                   blink_o,
  output logic                   buzzer_o,
  output logic                   caution_lamp_o,
  output logic                   error_o,
  output logic [7:0]             error_code_o,
  output logic [15:0]            turn_ratio_o,
  output logic                   first_interval_cc_o,
  output logic                   later_intervals_cc_o,
  output logic                   fast_rise_o,
  output logic [15:0]            corr_first_rise_interval_o,
  output logic [15:0]            corr_second_rise_interval_o,
  output logic                   irq_o
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic                  ack_reg;
  logic [31:0]           rdata_reg;
  logic                  count_en_reg;
  logic [3:0]            mode_reg;
  logic [CNT_W-1:0]      weld_preset_reg;
  logic [CNT_W-1:0]      work_preset_reg;
  logic [CNT_W-1:0]      weld_cnt_reg;
  logic [CNT_W-1:0]      work_cnt_reg;
  logic                  work_up_reg;
  logic [15:0]           max_curr_reg;
  logic [15:0]           ratio_reg;
  logic [15:0]           high_lim_reg;
  logic [15:0]           low_lim_reg;
  logic                  window_en_reg;
  weld_count_pkg::weld_mode_e weld_mode_reg;
  logic [15:0]           corr_g1_reg;
  logic [15:0]           corr_g2_reg;
  logic                  caution_reg;
  logic                  ratio_err_reg;
  logic                  por_check_reg;
  logic [31:0]           buzz_cnt_reg;
  logic [31:0]           beep_cnt_reg;
  logic                  beep_phase_reg;
  logic [weld_count_pkg::STATUS_W-1:0] status_reg;
  logic [weld_count_pkg::STATUS_W-1:0] mask_reg;

  logic                  wr_go;
  logic                  rd_go;
  logic                  key_reset;
  logic                  ext_clear;
  logic                  weld_clear;
  logic                  work_clear;
  logic                  weld_hit;
  logic                  work_hit;
  logic                  window_fail;
  logic                  mode_refused;
  logic [3:0]            mode_limit;
  logic [weld_count_pkg::STATUS_W-1:0] status_set;

  // access is accepted in the second cycle of a request, once ack is up
  assign waitrequest_o = (read_i | write_i) & ~ack_reg;
  assign wr_go         = write_i & ack_reg;
  assign rd_go         = read_i & ~ack_reg;
  assign readdata_o    = rdata_reg;

  // decode of a write to one register offset
  function automatic logic hit_wr(input logic [7:0] ofs);
    hit_wr = wr_go && (address_i == ofs);
  endfunction

  // ------------------------------------------------------------------
  // bus handshake and read data
  // ------------------------------------------------------------------
  // one wait cycle keeps the read mux out of the bus timing path
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read_i | write_i) & ~ack_reg;
  end

  // read data is captured while waitrequest is still high
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_reg <= 32'h0000_0000;
    else if (rd_go)
      rdata_reg <= read_mux(address_i);
  end

  function automatic logic [31:0] read_mux(input logic [7:0] ofs);
    read_mux = 32'h0000_0000;  // unmapped offsets read zero
    case (ofs)
      weld_count_pkg::CTRL_OFS:        read_mux[0] = count_en_reg;
      weld_count_pkg::MODE_SEL_OFS:    read_mux[3:0] = mode_reg;
      weld_count_pkg::MODE_DATA_OFS:   read_mux[15:0] = mode_data(mode_reg);
      weld_count_pkg::WELD_PRESET_OFS: read_mux[CNT_W-1:0] = weld_preset_reg;
      weld_count_pkg::WORK_PRESET_OFS: read_mux[CNT_W-1:0] = work_preset_reg;
      weld_count_pkg::WELD_COUNT_OFS:  read_mux[CNT_W-1:0] = weld_cnt_reg;
      weld_count_pkg::WORK_COUNT_OFS:  read_mux[CNT_W-1:0] = work_cnt_reg;
      weld_count_pkg::MAX_CURR_OFS:    read_mux[15:0] = max_curr_reg;
      weld_count_pkg::HIGH_LIM_OFS:    read_mux[15:0] = high_lim_reg;
      weld_count_pkg::LOW_LIM_OFS:     read_mux[15:0] = low_lim_reg;
      weld_count_pkg::STATUS_OFS:
        read_mux[weld_count_pkg::STATUS_W-1:0] = status_reg;
      weld_count_pkg::MASK_OFS:
        read_mux[weld_count_pkg::STATUS_W-1:0] = mask_reg;
      weld_count_pkg::ERROR_CODE_OFS:  read_mux[7:0] = error_code_o;
      default:                         read_mux = 32'h0000_0000;
    endcase
  endfunction

  // value of the data setter for the mode shown on the panel
  function automatic logic [15:0] mode_data(input logic [3:0] m);
    mode_data = 16'h0000;
    case (m)
      weld_count_pkg::MODE_WELD_CNT:   mode_data = 16'(weld_preset_reg);
      weld_count_pkg::MODE_WORK_CNT:   mode_data = 16'(work_preset_reg);
      weld_count_pkg::MODE_TURN_RATIO: mode_data = ratio_reg;
      weld_count_pkg::MODE_WINDOW:     mode_data = {15'h0000, window_en_reg};
      weld_count_pkg::MODE_WELD_SW:    mode_data = {14'h0000, weld_mode_reg};
      weld_count_pkg::MODE_CORR_G1:    mode_data = corr_g1_reg;
      weld_count_pkg::MODE_CORR_G2:    mode_data = corr_g2_reg;
      default:                         mode_data = 16'h0000;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // mode selector and panel settings
  // ------------------------------------------------------------------
  assign mode_limit = extended_mode_switch_i ? weld_count_pkg::MODE_MAX_EXT
                                             : weld_count_pkg::MODE_MAX_BASIC;

  // out-of-range selections are refused; a mode left above 7 when the
  // extended switch drops falls back to mode 0
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      mode_reg <= 4'h0;
    else if (hit_wr(weld_count_pkg::MODE_SEL_OFS)
             && writedata_i[3:0] <= mode_limit
             && writedata_i[31:4] == 28'h000_0000)
      mode_reg <= writedata_i[3:0];  // [RQ17]
    else if (mode_reg > mode_limit)
      mode_reg <= 4'h0;  // [RQ17]
  end

  // mode 7 values 1 and 2 need the method switch off
  assign mode_refused = hit_wr(weld_count_pkg::MODE_DATA_OFS)
                        && mode_reg == weld_count_pkg::MODE_WELD_SW
                        && (writedata_i[1:0] == 2'h3
                            || (writedata_i[1:0] != 2'h0
                                && control_method_switch_i));

  // the data setter writes whichever mode is selected
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      weld_preset_reg <= '0;
      work_preset_reg <= '0;
      ratio_reg       <= RATIO_INIT;
      window_en_reg   <= 1'b0;
      weld_mode_reg   <= weld_count_pkg::WELD_NORMAL;
      corr_g1_reg     <= weld_count_pkg::CORR_NOMINAL;
      corr_g2_reg     <= weld_count_pkg::CORR_NOMINAL;
    end
    else if (hit_wr(weld_count_pkg::MODE_DATA_OFS))
    begin
      case (mode_reg)
        weld_count_pkg::MODE_WELD_CNT:
          weld_preset_reg <= writedata_i[CNT_W-1:0];
        weld_count_pkg::MODE_WORK_CNT:
          work_preset_reg <= writedata_i[CNT_W-1:0];
        weld_count_pkg::MODE_TURN_RATIO:
          ratio_reg <= writedata_i[15:0];  // [RQ9]
        weld_count_pkg::MODE_WINDOW:
          window_en_reg <= writedata_i[0];
        weld_count_pkg::MODE_WELD_SW:
          if (!mode_refused)
            weld_mode_reg <= weld_count_pkg::weld_mode_e'(writedata_i[1:0]);
        weld_count_pkg::MODE_CORR_G1:
          corr_g1_reg <= writedata_i[15:0];  // [RQ15]
        weld_count_pkg::MODE_CORR_G2:
          corr_g2_reg <= writedata_i[15:0];  // [RQ16]
        default:
          weld_preset_reg <= weld_preset_reg;
      endcase
    end
    else if (hit_wr(weld_count_pkg::WELD_PRESET_OFS))
      weld_preset_reg <= writedata_i[CNT_W-1:0];
    else if (hit_wr(weld_count_pkg::WORK_PRESET_OFS))
      work_preset_reg <= writedata_i[CNT_W-1:0];
  end

  // plain settings outside the mode list
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_en_reg <= 1'b0;
      max_curr_reg <= MAX_CURR_INIT;
      high_lim_reg <= 16'hFFFF;
      low_lim_reg  <= 16'h0000;
      mask_reg     <= '0;
    end
    else
    begin
      if (hit_wr(weld_count_pkg::CTRL_OFS))
        count_en_reg <= writedata_i[weld_count_pkg::CTRL_COUNT_EN_BIT];
      if (hit_wr(weld_count_pkg::MAX_CURR_OFS))
        max_curr_reg <= writedata_i[15:0];
      if (hit_wr(weld_count_pkg::HIGH_LIM_OFS))
        high_lim_reg <= writedata_i[15:0];
      if (hit_wr(weld_count_pkg::LOW_LIM_OFS))
        low_lim_reg <= writedata_i[15:0];
      if (hit_wr(weld_count_pkg::MASK_OFS))
        mask_reg <= writedata_i[weld_count_pkg::STATUS_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // counter clears
  // ------------------------------------------------------------------
  assign key_reset  = hit_wr(weld_count_pkg::KEY_OFS)
                      && writedata_i[weld_count_pkg::KEY_RESET_BIT];
  // the external input is ignored entirely while interlock is on
  assign ext_clear  = ext_count_reset_i && !interlock_select_switch_i;
  assign weld_clear = (key_reset && mode_reg == weld_count_pkg::MODE_WELD_CNT)
                      || ext_clear;  // [RQ7]
  assign work_clear = (key_reset && mode_reg == weld_count_pkg::MODE_WORK_CNT)
                      || ext_clear;  // [RQ5] [RQ6]

  // ------------------------------------------------------------------
  // cascaded counters
  // ------------------------------------------------------------------
  // a zero weld preset never counts; a zero work preset never hits; the work counter stops at its preset
  assign weld_hit = weld_done_i && count_en_reg  // [RQ4]
                    && weld_preset_reg != '0
                    && weld_cnt_reg + CNT_W'(1) >= weld_preset_reg;
  assign work_hit = weld_hit && !work_up_reg && work_preset_reg != '0
                    && work_cnt_reg + CNT_W'(1) >= work_preset_reg;

  // clear wins over a weld in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      weld_cnt_reg <= '0;
    else if (weld_clear)
      weld_cnt_reg <= '0;  // [RQ19]
    else if (weld_hit)
      weld_cnt_reg <= '0;  // [RQ18]
    else if (weld_done_i && count_en_reg && weld_preset_reg != '0)
      weld_cnt_reg <= weld_cnt_reg + CNT_W'(1);  // [RQ4]
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      work_cnt_reg <= '0;
      work_up_reg  <= 1'b0;
    end
    else if (work_clear)
    begin
      work_cnt_reg <= '0;  // [RQ19]
      work_up_reg  <= 1'b0;  // [RQ19]
    end
    else if (weld_hit && !work_up_reg)
    begin
      work_cnt_reg <= work_cnt_reg + CNT_W'(1);  // [RQ1]
      work_up_reg  <= work_hit;  // [RQ2]
    end
  end

  // ------------------------------------------------------------------
  // buzzer and blink
  // ------------------------------------------------------------------
  // one second beep on each weld preset hit, restarted by a new hit
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      buzz_cnt_reg <= 32'h0000_0000;
    else if (weld_clear)
      buzz_cnt_reg <= 32'h0000_0000;  // [RQ19]
    else if (weld_hit)
      buzz_cnt_reg <= 32'(BUZZ_CYCLES);  // [RQ18]
    else if (buzz_cnt_reg != 32'h0000_0000)
      buzz_cnt_reg <= buzz_cnt_reg - 32'h0000_0001;
  end

  // half-period divider for blink and intermittent tone
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      beep_cnt_reg   <= 32'h0000_0000;
      beep_phase_reg <= 1'b0;
    end
    else if (!work_up_reg)
    begin
      beep_cnt_reg   <= 32'h0000_0000;
      beep_phase_reg <= 1'b0;
    end
    else if (beep_cnt_reg >= 32'(BEEP_CYCLES - 1))
    begin
      beep_cnt_reg   <= 32'h0000_0000;
      beep_phase_reg <= ~beep_phase_reg;
    end
    else
      beep_cnt_reg <= beep_cnt_reg + 32'h0000_0001;
  end

  assign blink_o      = work_up_reg && !beep_phase_reg;  // [RQ2]
  assign buzzer_o     = (buzz_cnt_reg != 32'h0000_0000)
                        || (work_up_reg && !beep_phase_reg);  // [RQ2] [RQ18]
  assign count_up_o   = work_up_reg && !interlock_select_switch_i;  // [RQ3]
  assign count_lamp_o = count_en_reg;  // [RQ4]

  // ------------------------------------------------------------------
  // power-on ratio check and current window
  // ------------------------------------------------------------------
  // checked once, the cycle after reset release; multiply avoids a divider
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      por_check_reg <= 1'b1;
      ratio_err_reg <= 1'b0;
    end
    else if (por_check_reg)
    begin
      por_check_reg <= 1'b0;
      ratio_err_reg <=
        32'(max_curr_reg) < weld_count_pkg::RATIO_MIN * 32'(ratio_reg)
        || 32'(max_curr_reg)
           > weld_count_pkg::RATIO_MAX * 32'(ratio_reg);  // [RQ8]
    end
  end

  assign window_fail = meas_valid_i && window_en_reg  // [RQ11]
                       && (meas_current_i > high_lim_reg
                           || meas_current_i < low_lim_reg);  // [RQ10]

  // caution stays lit until the operator clears it from the panel
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      caution_reg <= 1'b0;
    else if (window_fail)
      caution_reg <= 1'b1;  // [RQ10]
    else if (hit_wr(weld_count_pkg::KEY_OFS)
             && writedata_i[weld_count_pkg::KEY_CAUTION_CLR])
      caution_reg <= 1'b0;
  end

  assign caution_lamp_o = caution_reg;
  assign error_o        = caution_reg || ratio_err_reg;  // [RQ8] [RQ10]
  assign error_code_o   = ratio_err_reg ? weld_count_pkg::ERR_CODE_RATIO
                                        : 8'h00;  // [RQ8]

  // ------------------------------------------------------------------
  // control selection outputs
  // ------------------------------------------------------------------
  // method switch on selects supply-voltage compensation in normal mode;
  // modes 1 and 2 fall back to normal if the switch is turned on later
  always_comb
  begin
    first_interval_cc_o  = !control_method_switch_i;
    later_intervals_cc_o = !control_method_switch_i;  // [RQ12]
    fast_rise_o          = 1'b0;
    if (!control_method_switch_i)
    begin
      case (weld_mode_reg)
        weld_count_pkg::WELD_FAST_RISE:
        begin
          fast_rise_o = 1'b1;  // [RQ13]
        end
        weld_count_pkg::WELD_MIXED:
        begin
          fast_rise_o         = 1'b1;
          first_interval_cc_o = 1'b0;  // [RQ14]
        end
        default:
          fast_rise_o = 1'b0;
      endcase
    end
  end

  assign turn_ratio_o = primary_cc_select_i ? ratio_reg : 16'h0000;  // [RQ9]
  // corrections only take effect with the extended switch on
  assign corr_first_rise_interval_o  =
    extended_mode_switch_i ? corr_g1_reg : weld_count_pkg::CORR_NOMINAL;
  assign corr_second_rise_interval_o =
    extended_mode_switch_i ? corr_g2_reg : weld_count_pkg::CORR_NOMINAL;

  // ------------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------------
  always_comb
  begin
    status_set = '0;
    status_set[weld_count_pkg::ST_WELD_HIT]    = weld_hit;
    status_set[weld_count_pkg::ST_WORK_HIT]    = work_hit;
    status_set[weld_count_pkg::ST_WINDOW_FAIL] = window_fail;
    status_set[weld_count_pkg::ST_RATIO_ERR]   = por_check_reg
      && (32'(max_curr_reg) < weld_count_pkg::RATIO_MIN * 32'(ratio_reg)
          || 32'(max_curr_reg) > weld_count_pkg::RATIO_MAX * 32'(ratio_reg));
    status_set[weld_count_pkg::ST_REFUSED]     = mode_refused;
  end

  // write one to clear; a new event in the same cycle keeps its bit
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      status_reg <= '0;
    else if (hit_wr(weld_count_pkg::STATUS_OFS))
      status_reg <= (status_reg
                     & ~writedata_i[weld_count_pkg::STATUS_W-1:0])
                    | status_set;
    else
      status_reg <= status_reg | status_set;
  end

  assign irq_o = |(status_reg & mask_reg);

endmodule

/* verif/weld_ctl_checker.sv */
`timescale 1ns/1ps
module weld_ctl_checker (
  input wire logic sys_clk_i, reset_i, read_i, write_i, waitrequest_o,
  input wire logic interlock_select_switch_i, ext_count_reset_i,
  input wire logic meas_valid_i, count_up_o, caution_lamp_o, error_o,
  input wire logic [7:0] error_code_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_bus_wait: assert property ($rose(read_i || write_i) |->
    waitrequest_o ##1 !waitrequest_o) else $error("bus wait wrong");
  a_up_gate: assert property (
    count_up_o |-> !interlock_select_switch_i) else $error("up in lock");
  a_up_clear: assert property (
    ext_count_reset_i && !interlock_select_switch_i |=> !count_up_o)
    else $error("up kept");
  // a bus write may be the panel key, so it is left out of the hold;
  // the interlock switch gates the output directly
  a_up_hold: assert property (
    count_up_o && !write_i && !ext_count_reset_i
    |=> count_up_o == !interlock_select_switch_i) else $error("up lost");
  a_caution_err: assert property (
    caution_lamp_o |-> error_o) else $error("caution without error");
  a_caution_cause: assert property (
    $rose(caution_lamp_o) |-> $past(meas_valid_i)) else $error("caution");
  a_code_err: assert property (
    error_code_o == 8'h03 |-> error_o) else $error("code without error");
  a_code_hold: assert property (
    error_code_o == 8'h03 |=> error_code_o == 8'h03) else $error("code");
  c_up: cover property ($rose(count_up_o));
  c_caution: cover property ($rose(caution_lamp_o));
  c_code: cover property (error_code_o == 8'h03);
endmodule
bind weld_work_counter_control weld_ctl_checker u_chk (.*);

/* verif/weld_line_model.sv */
`timescale 1ns/1ps
// k welds, one each 4 cycles, each with a current sample
module weld_line_model (
  input  wire logic        sys_clk_i, start_i,
  input  wire logic [3:0]  welds_i,
  input  wire logic [15:0] amps_i,
  output logic             weld_done_o, meas_valid_o,
  output logic [15:0]      meas_current_o
);
  logic [5:0] left_reg = 6'h00;
  always @(posedge sys_clk_i)
    left_reg <= start_i ? {welds_i, 2'b00} : left_reg - (left_reg != 0);
  assign weld_done_o = left_reg[1:0] == 2'b01;
  assign meas_valid_o = weld_done_o;
  // off-sample the bus carries garbage, never the last value
  assign meas_current_o = meas_valid_o ? amps_i : ~amps_i;
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module tb;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
  logic interlock_select_switch_i = 1'b0, ext_count_reset_i = 1'b0;
  logic control_method_switch_i = 1'b0, extended_mode_switch_i = 1'b0;
  logic primary_cc_select_i = 1'b0, start = 1'b0, weld_done_i, meas_valid_i;
  logic [3:0] welds = 4'h0;
  logic [7:0] address_i = 8'h00, error_code_o;
  logic [15:0] amps = 16'h0000, meas_current_i, turn_ratio_o;
  logic [15:0] corr_first_rise_interval_o, corr_second_rise_interval_o;
  logic [31:0] writedata_i = 32'h0, readdata_o, rd;
  logic waitrequest_o, count_lamp_o, count_up_o, blink_o, buzzer_o, irq_o;
  logic caution_lamp_o, error_o, first_interval_cc_o, later_intervals_cc_o;
  logic fast_rise_o;
  int failures = 0, check_count = 0;
  // rows: offset, value written, value read back
  logic [7:0] ra [9] = '{8'h00, 8'h10, 8'h14, 8'h24, 8'h3C, 8'h34, 8'h30,
    8'h04, 8'h08};
  logic [31:0] rw [9] = '{32'h1, 32'h3, 32'h2, 32'h64, 32'h5, 32'hFF, 32'h1,
    32'h6, 32'h1};
  logic [31:0] re [9] = '{32'h1, 32'h3, 32'h2, 32'h64, 32'h0, 32'h3, 32'h1,
    32'h6, 32'h1};
  // ratio 201 makes the power-on check fail just past its limit
  weld_work_counter_control #(.BUZZ_CYCLES(20), .BEEP_CYCLES(4),
    .RATIO_INIT(16'h00C9)) u_dut (.*);
  weld_line_model u_line (.sys_clk_i, .start_i(start), .welds_i(welds),
    .amps_i(amps), .weld_done_o(weld_done_i), .meas_valid_o(meas_valid_i),
    .meas_current_o(meas_current_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until waitrequest is seen low at a rising edge; read data
  // is taken at that edge, compared once outputs settle on the falling one
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk_i);
    {address_i, writedata_i, write_i, read_i} <= {a, d, w, !w};
    do @(posedge sys_clk_i); while (waitrequest_o !== 1'b0 && ++n < 20);
    rd = readdata_o;
    {write_i, read_i} <= 2'b00;
    `CK(n < 20, 1'b1)
    if (n >= 20) conclude();
    @(negedge sys_clk_i);
    if (!w) `CK(rd, d)
  endtask
  task automatic weld(input logic [3:0] k, input logic [15:0] i,
                      input logic x);
    @(posedge sys_clk_i);
    {welds, amps, start, ext_count_reset_i} <= {k, i, 1'b1, x};
    @(posedge sys_clk_i);
    {start, ext_count_reset_i} <= 2'b00;
    repeat (4 * k + 4) @(negedge sys_clk_i);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int r = 0; r < 9; r++)
    begin
      bus(1'b1, ra[r], rw[r]);
      bus(1'b0, ra[r], re[r]);
    end
    `CK({irq_o, error_o}, 2'b01)
    weld(4'h6, 16'h32, 1'b0);
    bus(1'b0, 8'h1C, 32'h2);
    `CK({count_up_o, irq_o, caution_lamp_o}, 3'b110)
    `CK(buzzer_o, 1'b1)
    @(posedge sys_clk_i) interlock_select_switch_i <= 1'b1;
    weld(4'h0, 16'h0, 1'b1);
    bus(1'b0, 8'h1C, 32'h2);
    bus(1'b1, 8'h04, 32'h4);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b0, 8'h1C, 32'h0);
    $display("interlock on done");
    @(posedge sys_clk_i) interlock_select_switch_i <= 1'b0;
    weld(4'h5, 16'hC8, 1'b0);
    bus(1'b0, 8'h18, 32'h2);
    weld(4'h0, 16'h0, 1'b1);
    bus(1'b0, 8'h18, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    `CK({caution_lamp_o, blink_o, buzzer_o}, 3'b100)
    bus(1'b1, 8'h04, 32'h7);
    bus(1'b1, 8'h08, 32'h1);
    `CK({fast_rise_o, first_interval_cc_o}, 2'b11)
    bus(1'b1, 8'h08, 32'h2);
    `CK({fast_rise_o, first_interval_cc_o}, 2'b10)
    `CK(later_intervals_cc_o, 1'b1)
    bus(1'b1, 8'h04, 32'h8);
    bus(1'b0, 8'h04, 32'h7);
    `CK({turn_ratio_o, corr_first_rise_interval_o}, 32'h32)
    bus(1'b1, 8'h00, 32'h0);
    weld(4'h2, 16'h32, 1'b0);
    bus(1'b0, 8'h18, 32'h0);
    `CK(count_lamp_o, 1'b0)
    $display("interlock off done");
    conclude();
  end
endmodule
